/* verilog/mmbd_decode.sv */
// Program counter and data address decoder for a banked microcontroller memory map.
`timescale 1ns/1ns
`default_nettype none
module mmbd_decode
    import mmbd_pkg::*;
#(
    parameter bit SMALL_PROG = 1'h0                     // 1: only 4K words implemented
) (
    input  wire logic               ref_clk,            // Core clock, 50 MHz
    input  wire logic               resetn,             // Asynchronous reset, active low
    input  wire logic               pc_advance,         // Step to next instruction
    input  wire logic               pc_load,            // Load branch target
    input  wire logic [PC_W-1:0]    pc_target,          // Branch target
    input  wire logic               int_take,           // Interrupt accepted
    input  wire logic [7:0]         status_reg,         // Status register value
    input  wire logic [OFS_W-1:0]   instr_ofs,          // Offset field of the instruction
    input  wire logic               indirect_sel,       // Operand uses the pointer
    input  wire logic [PTR_W-1:0]   indirect_pointer,   // Pointer register value
    output logic [PC_W-1:0]         pc,                 // Program counter
    output logic [PC_W-1:0]         fetch_addr,         // Address on program bus
    output logic [1:0]              bank_sel,           // Selected data bank
    output mmbd_daddr_t             data_dec            // Decoded data address
);
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;

    // The counter stays 13 bits on both variants; only the bus address is cut
    wire logic [PC_W-1:0] size_mask = SMALL_PROG ? SIZE_4K_MASK : SIZE_8K_MASK;

    // Interrupt vector wins over a branch; both win over a plain step
    always_comb begin
        if (int_take) begin
            pc_d = INT_VEC;
        end else if (pc_load) begin
            pc_d = pc_target;
        end else if (pc_advance) begin
            pc_d = pc_q + PC_STEP;
        end else begin
            pc_d = pc_q;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pc_q <= RESET_VEC;
        end else begin
            pc_q <= pc_d;
        end
    end

    assign pc = pc_q;
    // Upper bit is ignored rather than faulting, so code past 4K aliases low
    assign fetch_addr = pc_q & size_mask;

    wire logic bs_high = status_reg[STAT_BSH_POS];
    wire logic bs_low  = status_reg[STAT_BSL_POS];
    assign bank_sel = {bs_high, bs_low};

    // Indirect: high bank bit joins the 8-bit pointer
    // Pointer bit 7 takes the place of bank_select_low, which indirect access ignores
    wire logic [DADDR_W-1:0] dir_addr = {bank_sel, instr_ofs};
    wire logic [DADDR_W-1:0] ind_addr = {bs_high, indirect_pointer};
    wire logic [DADDR_W-1:0] raw_addr = indirect_sel ? ind_addr : dir_addr;
    wire logic [OFS_W-1:0]   ofs      = raw_addr[OFS_W-1:0];

    wire logic is_sfr = (ofs < GPR_BASE);
    // Shared set: core registers, the page latch, interrupt control and the top RAM block
    wire logic shr_core  = (ofs >= MIR_LO) && (ofs <= MIR_HI);
    wire logic shr_page  = (ofs == MIR_PCH);
    wire logic shr_intc  = (ofs == MIR_INT);
    wire logic shr_ram   = (ofs >= MIR_RAM_LO);
    wire logic is_shared = shr_core || shr_page || shr_intc || shr_ram;
    // Shared offsets fold to bank 0 so one physical register serves all banks
    wire logic [DADDR_W-1:0] phys = is_shared ? {2'h0, ofs} : raw_addr;

    // Region NONE is never driven; storage outside the banks would use it
    always_comb begin
        data_dec.phys   = phys;
        data_dec.shared = is_shared;
        data_dec.region = is_sfr ? MMBD_REG_SFR : MMBD_REG_GPR;
    end

    // Program side: vectors, stepping, loading and the fetch address
    a_reset_vector: assert property (
        @(posedge ref_clk)
        $rose(resetn)
        |-> pc == RESET_VEC
    ) else $error("pc not at reset vector after reset");

    a_int_vector: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        int_take
        |=> pc == INT_VEC
    ) else $error("pc not at interrupt vector");

    a_int_priority: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        int_take && (pc_load || pc_advance)
        |=> pc == INT_VEC
    ) else $error("interrupt lost to a branch or step");

    a_pc_step: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        pc_advance && !pc_load && !int_take
        |=> pc == $past(pc) + PC_STEP
    ) else $error("pc did not advance by one");

    a_load_target: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        pc_load && !int_take
        |=> pc == $past(pc_target)
    ) else $error("pc did not take the branch target");

    a_pc_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !pc_advance && !pc_load && !int_take
        |=> pc == $past(pc)
    ) else $error("pc moved without a request");

    a_fetch_full: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !SMALL_PROG
        |-> fetch_addr == pc
    ) else $error("fetch address differs from pc");

    a_fetch_wrap: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        SMALL_PROG
        |-> fetch_addr[PC_W-1] == 1'h0 && fetch_addr[PC_W-2:0] == pc[PC_W-2:0]
    ) else $error("fetch address not wrapped");

    a_small_range: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        SMALL_PROG
        |-> fetch_addr <= SIZE_4K_MASK
    ) else $error("fetch address beyond implemented words");

    a_fetch_stable: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $stable(pc)
        |-> $stable(fetch_addr)
    ) else $error("fetch address moved by data side");

    // Data side: bank bits, address forming, regions and shared registers
    a_bank_bits: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        1'h1
        |-> bank_sel == {status_reg[STAT_BSH_POS], status_reg[STAT_BSL_POS]}
    ) else $error("bank select mismatch");

    a_direct_addr: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !indirect_sel && !data_dec.shared
        |-> data_dec.phys == {status_reg[STAT_BSH_POS], status_reg[STAT_BSL_POS], instr_ofs}
    ) else $error("direct address wrong");

    a_indirect_addr: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        indirect_sel
        |-> data_dec.phys[OFS_W-1:0] == indirect_pointer[OFS_W-1:0]
    ) else $error("indirect offset wrong");

    a_indirect_bank: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        indirect_sel && !data_dec.shared
        |-> data_dec.phys == {status_reg[STAT_BSH_POS], indirect_pointer}
    ) else $error("indirect address wrong");

    a_offset_kept: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !indirect_sel
        |-> data_dec.phys[OFS_W-1:0] == instr_ofs
    ) else $error("in-bank offset altered");

    a_sfr_low: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        1'h1
        |-> (data_dec.region == MMBD_REG_SFR) == (data_dec.phys[OFS_W-1:0] < GPR_BASE)
    ) else $error("region decode wrong");

    a_sfr_bank_kept: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !indirect_sel && !data_dec.shared && data_dec.region == MMBD_REG_SFR
        |-> data_dec.phys[DADDR_W-1:OFS_W] == bank_sel
    ) else $error("special register left its bank");

    a_gpr_high: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_dec.region == MMBD_REG_GPR
        |-> data_dec.phys[OFS_W-1:0] >= GPR_BASE
    ) else $error("general storage below special region");

    a_region_known: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        1'h1
        |-> data_dec.region != MMBD_REG_NONE
    ) else $error("offset decoded to no region");

    a_mirror_fold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        data_dec.shared
        |-> data_dec.phys[DADDR_W-1:OFS_W] == 2'h0
    ) else $error("shared register not folded");

    a_data_stable: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $stable(status_reg) && $stable(instr_ofs) && $stable(indirect_sel)
        && $stable(indirect_pointer)
        |-> $stable(data_dec)
    ) else $error("data decode moved by program side");

endmodule
`default_nettype wire

/* verilog/mmbd_pkg.sv */
// Package for the memory map and bank decode block: sizes, vectors, field positions.
`default_nettype none
package mmbd_pkg;
    localparam int unsigned PC_W         = 13;
    localparam int unsigned INSTR_W      = 14;
    localparam int unsigned OFS_W        = 7;
    localparam int unsigned DADDR_W      = 9;
    localparam int unsigned PTR_W        = 8;
    localparam int unsigned BANK_W       = 2;
    localparam int unsigned STAT_BSH_POS = 6;
    localparam int unsigned STAT_BSL_POS = 5;
    localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
    localparam logic [PC_W-1:0] INT_VEC   = 13'h0004;
    localparam logic [PC_W-1:0] SIZE_4K_MASK = 13'h0FFF;
    localparam logic [PC_W-1:0] SIZE_8K_MASK = 13'h1FFF;
    localparam logic [OFS_W-1:0] BANK_TOP   = 7'h7F;
    // Special function region ends below this offset; general storage above
    localparam logic [OFS_W-1:0] GPR_BASE   = 7'h20;
    // Offsets whose register is shared by all banks
    localparam logic [OFS_W-1:0] MIR_LO     = 7'h00;
    localparam logic [OFS_W-1:0] MIR_HI     = 7'h04;
    localparam logic [OFS_W-1:0] MIR_PCH    = 7'h0A;
    localparam logic [OFS_W-1:0] MIR_INT    = 7'h0B;
    localparam logic [OFS_W-1:0] MIR_RAM_LO = 7'h70;
    localparam logic [PC_W-1:0] PC_STEP     = 13'h0001;

    typedef enum logic [1:0] {MMBD_REG_NONE, MMBD_REG_SFR, MMBD_REG_GPR} mmbd_region_t;

    typedef struct packed {
        logic [DADDR_W-1:0] phys;    // Bank-folded address seen by storage
        mmbd_region_t       region;
        logic               shared;  // Decodes to the same register in every bank
    } mmbd_daddr_t;
endpackage
`default_nettype wire

/* test/mmbd_core_model.sv */
// Core-side model: drives program counter controls and operand fields.
`timescale 1ns/1ns
`default_nettype none
module mmbd_core_model
    import mmbd_pkg::*;
(
    input  wire logic         ref_clk,          // Core clock
    output logic              pc_advance,       // Step request
    output logic              pc_load,          // Branch request
    output logic              int_take,         // Interrupt taken
    output logic [PC_W-1:0]   pc_target,        // Branch target
    output logic [7:0]        status_reg,       // Status byte
    output logic [OFS_W-1:0]  instr_ofs,        // Instruction offset
    output logic              indirect_sel,     // Pointer mode
    output logic [PTR_W-1:0]  indirect_pointer  // Pointer value
);
    initial begin
        {pc_advance, pc_load, int_take, pc_target} = '0;
        {status_reg, instr_ofs, indirect_sel, indirect_pointer} = '0;
    end
    // Controls launch just after an edge and hold for one whole cycle
    task automatic step(input logic [2:0] ctl, input logic [PC_W-1:0] tgt);
        @(posedge ref_clk);
        #2;
        {pc_advance, pc_load, int_take} = ctl;
        pc_target = tgt;
    endtask
    // The unused field carries the inverse, so a wrong source selection shows
    task automatic operand(input logic [7:0] st, input logic [7:0] v, input logic ind);
        status_reg = st;
        indirect_sel = ind;
        indirect_pointer = ind ? v : ~v;
        instr_ofs = ind ? ~v[6:0] : v[6:0];
    endtask
endmodule
`default_nettype wire

/* test/memory_map_bank_decode_bench.sv */
// Self-checking bench for the memory map and bank decode block.
`timescale 1ns/1ns
`default_nettype none
module memory_map_bank_decode_bench;
    import mmbd_pkg::*;
    logic ref_clk = 0, resetn = 0, adv, ld, it, isel;
    logic [PC_W-1:0] tgt, pc, fa, fa_s;
    logic [7:0] st, ptr;
    logic [OFS_W-1:0] ofs;
    logic [1:0] bank;
    mmbd_daddr_t dd;
    int n_errors = 0, check_count = 0;
    mmbd_core_model core(.ref_clk(ref_clk), .pc_advance(adv), .pc_load(ld), .int_take(it),
        .pc_target(tgt), .status_reg(st), .instr_ofs(ofs), .indirect_sel(isel),
        .indirect_pointer(ptr));
    mmbd_decode mmbd_decode_inst(.ref_clk(ref_clk), .resetn(resetn), .pc_advance(adv),
        .pc_load(ld), .pc_target(tgt), .int_take(it), .status_reg(st), .instr_ofs(ofs),
        .indirect_sel(isel), .indirect_pointer(ptr), .pc(pc), .fetch_addr(fa),
        .bank_sel(bank), .data_dec(dd));
    mmbd_decode #(.SMALL_PROG(1'h1)) small_mmbd_decode_inst(.ref_clk(ref_clk),
        .resetn(resetn), .pc_advance(adv), .pc_load(ld), .pc_target(tgt), .int_take(it),
        .status_reg(st), .instr_ofs(ofs), .indirect_sel(isel), .indirect_pointer(ptr),
        .pc(), .fetch_addr(fa_s), .bank_sel(), .data_dec());
    initial forever #10 ref_clk = ~ref_clk;
    task automatic check(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic dec(input logic [7:0] s, v, input logic ind, input logic [8:0] ph,
                       input mmbd_region_t rg, input logic sh);
        @(posedge ref_clk);
        #2;
        core.operand(s, v, ind);
        #1;
        check("bank_sel", 16'(bank), 16'(s[6:5]));
        check("phys", 16'(dd.phys), 16'(ph));
        check("region", 16'(dd.region), 16'(rg));
        check("shared", 16'(dd.shared), 16'(sh));
    endtask
    task automatic pc_flow();
        core.step(3'h3, 13'h0123);
        core.step(3'h4, '0);
        check("pc_int", 16'(pc), 16'(INT_VEC));
        core.step(3'h0, '0);
        check("pc_step", 16'(pc), 16'h0005);
        core.step(3'h2, 13'h1FFF);
        core.step(3'h4, '0);
        core.operand(8'h60, 8'h30, 1'h0);
        #1;
        check("fetch_8k", 16'(fa), 16'h1FFF);
        check("fetch_4k", 16'(fa_s), 16'h0FFF);
        check("phys_with_fetch", 16'(dd.phys), 16'h01B0);
        core.step(3'h2, 13'h0AAA);
        check("pc_wrap", 16'(pc), 16'h0000);
        core.step(3'h0, '0);
        check("pc_load", 16'(pc), 16'h0AAA);
        resetn = 0;
        #1 check("pc_reset", 16'(pc), 16'(RESET_VEC));
        @(posedge ref_clk);
        #2 resetn = 1;
        $display("Test pc_flow done");
    endtask
    task automatic data_map();
        dec(8'h00, 8'h25, 1'h0, 9'h025, MMBD_REG_GPR, 1'h0);
        dec(8'h20, 8'h25, 1'h0, 9'h0A5, MMBD_REG_GPR, 1'h0);
        dec(8'h40, 8'h05, 1'h0, 9'h105, MMBD_REG_SFR, 1'h0);
        dec(8'h60, 8'h1F, 1'h0, 9'h19F, MMBD_REG_SFR, 1'h0);
        dec(8'h60, 8'h20, 1'h0, 9'h1A0, MMBD_REG_GPR, 1'h0);
        dec(8'h60, 8'h6F, 1'h0, 9'h1EF, MMBD_REG_GPR, 1'h0);
        dec(8'h60, 8'h7F, 1'h0, 9'h07F, MMBD_REG_GPR, 1'h1);
        dec(8'h40, 8'h03, 1'h0, 9'h003, MMBD_REG_SFR, 1'h1);
        dec(8'h20, 8'h04, 1'h0, 9'h004, MMBD_REG_SFR, 1'h1);
        dec(8'h20, 8'h0A, 1'h0, 9'h00A, MMBD_REG_SFR, 1'h1);
        dec(8'h60, 8'h0B, 1'h0, 9'h00B, MMBD_REG_SFR, 1'h1);
        dec(8'hA0, 8'h05, 1'h0, 9'h085, MMBD_REG_SFR, 1'h0);
        dec(8'h40, 8'hA5, 1'h1, 9'h1A5, MMBD_REG_GPR, 1'h0);
        dec(8'h20, 8'h85, 1'h1, 9'h085, MMBD_REG_SFR, 1'h0);
        $display("Test data_map done");
    endtask
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        #2 resetn = 1;
        pc_flow();
        data_map();
        complete_run();
    end
    initial begin
        #20000 n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
